// ---- logic/sers_pkg.sv ----
/*
  Shared constants and carrier types for the sector error recovery and
  sparing block. Assumes one system clock and one synchronous reset.
*/
package sers_pkg;

  // ===========================================================
  // correction code geometry
  localparam int SERS_SYN_BITS      = 288;
  localparam int SERS_XC_BITS       = 8;
  localparam int SERS_BURSTS        = 4;
  localparam int SERS_BURST_BYTES   = 4;
  localparam int SERS_RANDOM_BYTES  = 16;
  localparam logic [7:0] SERS_XC_CLEAN_LO = 8'h00;
  localparam logic [7:0] SERS_XC_CLEAN_HI = 8'hff;

  // ===========================================================
  // retry, media test and verify sequencing
  localparam logic [3:0] SERS_RETRY_STEPS   = 4'h8;
  localparam int         SERS_TEST_PASSES   = 4;
  localparam int         SERS_VERIFY_PASSES = 3;
  localparam logic [3:0] SERS_TEST_LAST     = 4'(2 * SERS_TEST_PASSES - 1);
  localparam logic [3:0] SERS_VERIFY_LAST   = 4'(3 * SERS_VERIFY_PASSES - 1);

  // ===========================================================
  // defect management
  localparam int         SERS_ZONES      = 30;
  localparam logic [5:0] SERS_SPARES     = 6'h20;
  localparam logic [8:0] SERS_GROWN_MAX  = 9'h1f4;
  localparam int         SERS_PEND_N     = 8;
  localparam int         SERS_FACT_N     = 8;
  localparam int         SERS_LBA_W      = 32;
  localparam int         SERS_FIFO_DEPTH = 16;
  localparam logic       SERS_AUTO_REALLOC_RST = 1'b1;

  // ===========================================================
  // carriers
  typedef enum logic [1:0] {RES_OK, RES_CORRECTED, RES_FAILED} sers_result_type;
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_VERIFY} sers_op_type;

  typedef struct packed {
    logic [SERS_SYN_BITS-1:0] main;
    logic [SERS_XC_BITS-1:0]  cross_check_syndrome;
  } sers_syn_type;

  typedef struct packed {
    logic         otf_ok;
    sers_syn_type syn;
  } sers_sector_end_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } sers_byte_type;

  typedef struct packed {
    logic [SERS_LBA_W-1:0] lba;
    logic [4:0]            zone;
    logic [4:0]            slot;
    logic                  permanent;
  } sers_remap_type;

endpackage : sers_pkg

// ---- logic/sers_top.sv ----
/*
  Sector error recovery and sparing: a byte FIFO toward the host buffer,
  retry/firmware-correction sequencing, media test, zoned spare pools,
  pending and factory defect lists. Assumes the read channel applies the
  on-the-fly correction to the bytes and reports syndromes at sector end,
  and that firmware and the media layer answer request pulses.
*/
`timescale 1ns/1ps

// ===========================================================
// fifo with registered output stage
module sers_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 16
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ovld;
    logic [W-1:0]            odat;
    logic                    irdy;
  } sers_fifo_state_type;

  sers_fifo_state_type s_reg, s_next;
  logic push, load;

  always_comb begin
    s_next = s_reg;
    push = in_valid && s_reg.irdy;
    load = (s_reg.cnt != '0) && (!s_reg.ovld || out_ready);
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (load) begin
      s_next.odat = s_reg.mem[s_reg.rp];
      s_next.rp   = s_reg.rp + 1'b1;
      s_next.ovld = 1'b1;
    end else if (out_ready) begin
      s_next.ovld = 1'b0;
    end
    s_next.cnt  = s_reg.cnt + (AW+1)'(push) - (AW+1)'(load);
    // full is judged from the next count so a push never overruns
    s_next.irdy = (s_next.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg      <= '0;
      s_reg.irdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready  = s_reg.irdy;
  assign out_valid = s_reg.ovld;
  assign out_data  = s_reg.odat;
endmodule : sers_fifo

// ===========================================================
// recovery and sparing controller
module sers_top
  import sers_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  rc_valid,
  output      logic                  rc_ready,
  input  wire sers_byte_type         rc_byte,
  input  wire logic                  rc_end,
  input  wire sers_sector_end_type   rc_status,
  output      logic                  buf_valid,
  input  wire logic                  buf_ready,
  output      sers_byte_type         buf_byte,
  input  wire logic                  rd_start,
  input  wire logic                  wr_start,
  input  wire logic [SERS_LBA_W-1:0] cmd_lba,
  input  wire logic [4:0]            cmd_zone,
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_auto_realloc,
  input  wire logic                  fact_load,
  input  wire logic [SERS_LBA_W-1:0] fact_lba,
  input  wire logic                  fw_done,
  input  wire logic                  fw_ok,
  input  wire logic                  med_ack,
  input  wire logic                  med_ok,
  input  wire logic                  med_need_fw,
  output      logic [SERS_LBA_W-1:0] phys_addr,
  output      logic                  reread_req,
  output      logic                  fw_req,
  output      sers_syn_type          fw_syn,
  output      logic                  med_req,
  output      sers_op_type           med_op,
  output      logic                  remap_valid,
  output      sers_remap_type        remap,
  output      logic                  done,
  output      sers_result_type       result,
  output      logic                  list_full,
  output      logic                  auto_realloc,
  output      logic [8:0]            grown_count
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_FIRST, ST_RR_WAIT, ST_FW_WAIT, ST_TEST, ST_TEST_WAIT,
    ST_SPARE, ST_VERIFY, ST_VER_WAIT
  } sers_state_type;

  typedef struct packed {
    sers_state_type                         st;
    logic [SERS_LBA_W-1:0]                  lba;
    logic [4:0]                             zone;
    logic [3:0]                             retries;
    logic [3:0]                             step;
    logic                                   fail;
    logic                                   wr_path;
    logic [2:0]                             pidx;
    sers_syn_type                           syn;
    logic                                   auto_realloc;
    logic [SERS_ZONES-1:0][5:0]             pools;
    logic [8:0]                             grown;
    logic [SERS_PEND_N-1:0][SERS_LBA_W-1:0] pend;
    logic [SERS_PEND_N-1:0]                 pend_v;
    logic [SERS_FACT_N-1:0][SERS_LBA_W-1:0] fact;
    logic [3:0]                             fact_n;
    logic [SERS_LBA_W-1:0]                  phys;
    logic                                   reread;
    logic                                   fw;
    logic                                   med;
    sers_op_type                            op;
    logic                                   remap_v;
    sers_remap_type                         remap;
    logic                                   done;
    sers_result_type                        res;
    logic                                   full;
  } sers_ctl_state_type;

  sers_ctl_state_type s_reg, s_next;

  // ===========================================================
  // helpers
  function automatic logic sers_clean(input sers_syn_type syn);
    return (syn.main == '0) &&
           (syn.cross_check_syndrome == SERS_XC_CLEAN_LO ||
            syn.cross_check_syndrome == SERS_XC_CLEAN_HI);
  endfunction : sers_clean

  // factory list is loaded in ascending order; each hit shifts by one
  function automatic logic [SERS_LBA_W-1:0] sers_map(
    input logic [SERS_FACT_N-1:0][SERS_LBA_W-1:0] fact,
    input logic [3:0]                             n,
    input logic [SERS_LBA_W-1:0]                  lba);
    logic [SERS_LBA_W-1:0] p;
    p = lba;
    for (int i = 0; i < SERS_FACT_N; i++) begin
      if (4'(i) < n && fact[i] <= p) begin
        p = p + 1'b1;
      end
    end
    return p;
  endfunction : sers_map

  // {found, zone} of the closest pool that still holds spares
  function automatic logic [5:0] sers_nearest(
    input logic [SERS_ZONES-1:0][5:0] pools,
    input logic [4:0]                 home);
    logic [5:0] best;
    logic [5:0] bd;
    logic [5:0] d;
    best = '0;
    bd   = 6'h3f;
    for (int i = 0; i < SERS_ZONES; i++) begin
      d = (5'(i) > home) ? {1'b0, 5'(i) - home} : {1'b0, home - 5'(i)};
      if (pools[i] != '0 && d < bd) begin
        bd   = d;
        best = {1'b1, 5'(i)};
      end
    end
    return best;
  endfunction : sers_nearest

  // test alternates write/read; verify cycles write, read, verify
  function automatic sers_op_type sers_op_of(input logic [3:0] step,
                                             input logic       verify);
    if (verify) begin
      return (step % 4'h3 == 4'h0) ? OP_WRITE :
             (step % 4'h3 == 4'h1) ? OP_READ : OP_VERIFY;
    end
    return step[0] ? OP_READ : OP_WRITE;
  endfunction : sers_op_of

  // ===========================================================
  // controller
  logic [5:0]            near;
  logic                  hit;
  logic [2:0]            hit_idx;
  logic                  free;
  logic [2:0]            free_idx;

  always_comb begin
    s_next = s_reg;
    s_next.reread  = 1'b0;
    s_next.fw      = 1'b0;
    s_next.med     = 1'b0;
    s_next.remap_v = 1'b0;
    s_next.done    = 1'b0;
    near     = sers_nearest(s_reg.pools, s_reg.zone);
    hit      = 1'b0;
    hit_idx  = '0;
    free     = 1'b0;
    free_idx = '0;
    for (int i = SERS_PEND_N - 1; i >= 0; i--) begin
      if (s_reg.pend_v[i] && s_reg.pend[i] == cmd_lba) begin
        hit     = 1'b1;
        hit_idx = 3'(i);
      end
      if (!s_reg.pend_v[i]) begin
        free     = 1'b1;
        free_idx = 3'(i);
      end
    end
    if (cfg_wr) begin
      s_next.auto_realloc = cfg_auto_realloc;
    end
    if (fact_load && s_reg.fact_n < 4'(SERS_FACT_N)) begin
      s_next.fact[s_reg.fact_n[2:0]] = fact_lba;
      s_next.fact_n = s_reg.fact_n + 1'b1;
    end
    case (s_reg.st)
      ST_IDLE: begin
        s_next.lba  = cmd_lba;
        s_next.zone = cmd_zone;
        s_next.phys = sers_map(s_reg.fact, s_reg.fact_n, cmd_lba);
        s_next.step = '0;
        s_next.fail = 1'b0;
        s_next.pidx = hit_idx;
        if (rd_start) begin
          s_next.retries = '0;
          s_next.wr_path = 1'b0;
          s_next.st      = ST_FIRST;
        end else if (wr_start && hit) begin
          s_next.wr_path = 1'b1;
          s_next.st      = ST_VERIFY;
        end else if (wr_start) begin
          s_next.done = 1'b1;
          s_next.res  = RES_OK;
        end
      end
      ST_FIRST: begin
        if (rc_end) begin
          s_next.syn = rc_status.syn;
          if (rc_status.otf_ok) begin
            // bytes already streamed through; nothing to hold back
            s_next.done = 1'b1;
            s_next.res  = RES_OK;
            s_next.st   = ST_IDLE;
          end else begin
            s_next.reread  = 1'b1;
            s_next.retries = s_reg.retries + 1'b1;
            s_next.st      = ST_RR_WAIT;
          end
        end
      end
      ST_RR_WAIT: begin
        if (rc_end) begin
          if (sers_clean(rc_status.syn)) begin
            s_next.done = 1'b1;
            s_next.res  = RES_OK;
            s_next.st   = ST_IDLE;
          end else begin
            s_next.syn = rc_status.syn;
            if (s_reg.retries == SERS_RETRY_STEPS) begin
              s_next.fw = 1'b1;
              s_next.st = ST_FW_WAIT;
            end else begin
              s_next.reread  = 1'b1;
              s_next.retries = s_reg.retries + 1'b1;
            end
          end
        end
      end
      ST_FW_WAIT: begin
        if (fw_done && fw_ok && s_reg.auto_realloc) begin
          s_next.st = ST_TEST;
        end else if (fw_done && fw_ok) begin
          s_next.done = 1'b1;
          s_next.res  = RES_CORRECTED;
          s_next.st   = ST_IDLE;
        end else if (fw_done) begin
          if (free) begin
            s_next.pend[free_idx]   = s_reg.lba;
            s_next.pend_v[free_idx] = 1'b1;
          end else begin
            s_next.full = 1'b1;
          end
          s_next.done = 1'b1;
          s_next.res  = RES_FAILED;
          s_next.st   = ST_IDLE;
        end
      end
      ST_TEST: begin
        s_next.med = 1'b1;
        s_next.op  = sers_op_of(s_reg.step, 1'b0);
        s_next.st  = ST_TEST_WAIT;
      end
      ST_TEST_WAIT: begin
        if (med_ack) begin
          if (!med_ok || (s_reg.op == OP_READ && med_need_fw)) begin
            s_next.fail = 1'b1;
          end
          s_next.step = s_reg.step + 1'b1;
          if (s_reg.step != SERS_TEST_LAST) begin
            s_next.st = ST_TEST;
          end else if (s_next.fail) begin
            s_next.st = ST_SPARE;
          end else begin
            s_next.done = 1'b1;
            s_next.res  = RES_CORRECTED;
            s_next.st   = ST_IDLE;
          end
        end
      end
      ST_SPARE: begin
        s_next.st   = ST_IDLE;
        s_next.done = 1'b1;
        if (near[5] && s_reg.grown != SERS_GROWN_MAX) begin
          s_next.pools[near[4:0]] = s_reg.pools[near[4:0]] - 1'b1;
          s_next.grown            = s_reg.grown + 1'b1;
          s_next.remap_v          = 1'b1;
          s_next.remap.lba        = s_reg.lba;
          s_next.remap.zone       = near[4:0];
          s_next.remap.slot       = 5'(s_next.pools[near[4:0]]);
          s_next.remap.permanent  = s_reg.wr_path;
          s_next.res = s_reg.wr_path ? RES_OK : RES_CORRECTED;
        end else begin
          // no spare or list at its limit: data is not relocated
          s_next.full = 1'b1;
          s_next.res  = RES_FAILED;
        end
      end
      ST_VERIFY: begin
        s_next.med = 1'b1;
        s_next.op  = sers_op_of(s_reg.step, 1'b1);
        s_next.st  = ST_VER_WAIT;
      end
      ST_VER_WAIT: begin
        if (med_ack) begin
          if (!med_ok) begin
            s_next.fail = 1'b1;
          end
          s_next.step = s_reg.step + 1'b1;
          if (s_reg.step != SERS_VERIFY_LAST) begin
            s_next.st = ST_VERIFY;
          end else begin
            s_next.pend_v[s_reg.pidx] = 1'b0;
            if (s_next.fail) begin
              s_next.st = ST_SPARE;
            end else begin
              s_next.done = 1'b1;
              s_next.res  = RES_OK;
              s_next.st   = ST_IDLE;
            end
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg              <= '0;
      s_reg.st           <= ST_IDLE;
      s_reg.auto_realloc <= SERS_AUTO_REALLOC_RST;
      s_reg.pools        <= {SERS_ZONES{SERS_SPARES}};
    end else begin
      s_reg <= s_next;
    end
  end

  // ===========================================================
  // data path: read channel stalls on a full buffer
  sers_fifo #(
    .W     ($bits(sers_byte_type)),
    .DEPTH (SERS_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (rc_valid),
    .in_ready  (rc_ready),
    .in_data   (rc_byte),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_byte)
  );

  assign phys_addr    = s_reg.phys;
  assign reread_req   = s_reg.reread;
  assign fw_req       = s_reg.fw;
  assign fw_syn       = s_reg.syn;
  assign med_req      = s_reg.med;
  assign med_op       = s_reg.op;
  assign remap_valid  = s_reg.remap_v;
  assign remap        = s_reg.remap;
  assign done         = s_reg.done;
  assign result       = s_reg.res;
  assign list_full    = s_reg.full;
  assign auto_realloc = s_reg.auto_realloc;
  assign grown_count  = s_reg.grown;
endmodule : sers_top

// ---- verification/sers_media_model.sv ----
/* Media layer and firmware correction answering sers_top requests.
   Assumes request pulses; one op index counted per command. */
`timescale 1ns/1ps
module sers_media_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       med_req,
  input  wire logic       fw_req,
  input  wire logic       done,
  input  wire logic       fw_good,
  input  wire logic       fail_fw,
  input  wire logic [3:0] fail_at,
  output      logic       med_ack,
  output      logic       med_ok,
  output      logic       med_need_fw,
  output      logic       fw_done,
  output      logic       fw_ok
);
  logic [3:0] idx_reg;
  logic [2:0] mw_reg, fw_reg;
  initial {med_ack, med_ok, med_need_fw, fw_done, fw_ok} = 5'h0;
  // answers hold only in their cycle, junk otherwise
  always @(posedge mclk) begin
    med_ack <= 1'b0;
    fw_done <= 1'b0;
    med_ok <= ~med_ok;
    med_need_fw <= ~med_need_fw;
    fw_ok <= ~fw_ok;
    if (rst || done) idx_reg <= 4'h0;
    if (rst) begin
      mw_reg <= 3'h0;
      fw_reg <= 3'h0;
    end else begin
      // odd ops answer slowly
      if (med_req) mw_reg <= idx_reg[0] ? 3'h4 : 3'h1;
      else if (mw_reg != 3'h0) mw_reg <= mw_reg - 3'h1;
      if (mw_reg == 3'h1) begin
        med_ack <= 1'b1;
        med_ok <= !(idx_reg == fail_at && !fail_fw);
        med_need_fw <= idx_reg == fail_at && fail_fw;
        idx_reg <= idx_reg + 4'h1;
      end
      if (fw_req) fw_reg <= 3'h3;
      else if (fw_reg != 3'h0) fw_reg <= fw_reg - 3'h1;
      if (fw_reg == 3'h1) begin
        fw_done <= 1'b1;
        fw_ok <= fw_good;
      end
    end
  end
endmodule : sers_media_model

// ---- verification/sers_properties.sv ----
/* Checker for sers_top, attached by the bind at the foot.
   Assumes starts come only while idle and rc_end only in reads. */
`timescale 1ns/1ps
module sers_properties
  import sers_pkg::*;
(
  input wire logic                mclk, rst, rd_start, wr_start, rc_end,
  input wire sers_sector_end_type rc_status,
  input wire logic                reread_req, fw_req, fw_done, fw_ok,
  input wire logic                med_req, remap_valid, done,
  input wire logic                auto_realloc, list_full,
  input wire sers_syn_type        fw_syn,
  input wire sers_op_type         med_op,
  input wire sers_remap_type      remap,
  input wire sers_result_type     result,
  input wire logic [8:0]          grown_count
);
  // ==========
  // re-reads and media ops of the current command
  logic [3:0] rr_reg, mo_reg;
  logic       dirty;
  assign dirty = rc_status.syn.main != '0 ||
    !(rc_status.syn.cross_check_syndrome inside
      {SERS_XC_CLEAN_LO, SERS_XC_CLEAN_HI});
  always_ff @(posedge mclk) begin
    if (rst || rd_start || wr_start) begin
      rr_reg <= 4'h0;
      mo_reg <= 4'h0;
    end else begin
      rr_reg <= rr_reg + 4'(reread_req);
      mo_reg <= mo_reg + 4'(med_req);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_RESET_VAL: assert property ($past(rst) |-> auto_realloc &&
    grown_count == 9'h0) else $error("bad value after reset");
  AST_OTF_PASS: assert property (rc_end && rc_status.otf_ok &&
    rr_reg == 4'h0 |=> done && result == RES_OK && !reread_req)
    else $error("on the fly sector not passed");
  AST_DIRTY_REREAD: assert property (rc_end && !rc_status.otf_ok &&
    dirty && rr_reg < SERS_RETRY_STEPS |=> reread_req && !fw_req)
    else $error("no re-read after bad syndromes");
  AST_CLEAN_DONE: assert property (rc_end && !rc_status.otf_ok &&
    !dirty && rr_reg != 4'h0 |=> done && result == RES_OK)
    else $error("clean re-read not delivered");
  AST_FW_LAST: assert property (rc_end && dirty &&
    rr_reg == SERS_RETRY_STEPS |=> fw_req &&
    fw_syn == $past(rc_status.syn)) else $error("no firmware fix");
  AST_FW_FAIL: assert property (fw_done && !fw_ok |=>
    done && result == RES_FAILED) else $error("failed fix not reported");
  AST_TEST_START: assert property (fw_done && fw_ok &&
    auto_realloc |-> ##[1:2] (med_req && med_op == OP_WRITE))
    else $error("media test not started with a write");
  AST_TEST_LEN: assert property (done && result == RES_CORRECTED &&
    !remap_valid && mo_reg != 4'h0 |-> mo_reg == 4'h8)
    else $error("media test length wrong");
  AST_REMAP_DONE: assert property (remap_valid |-> done &&
    $stable(list_full) && remap.zone < 5'd30) else $error("bad remap");
  cover property (fw_req);
  cover property (remap_valid && remap.permanent);
  cover property (done && result == RES_CORRECTED);
endmodule : sers_properties

bind sers_top sers_properties chk_u (.mclk, .rst, .rd_start, .wr_start,
  .rc_end, .rc_status, .reread_req, .fw_req, .fw_done, .fw_ok, .med_req,
  .remap_valid, .done, .auto_realloc, .list_full, .fw_syn, .med_op,
  .remap, .result, .grown_count);

// ---- verification/sers_tb_top.sv ----
/* Bench for sers_top: scenario tasks drive the read channel and
   commands; the model answers media and firmware requests. */
`timescale 1ns/1ps
module sers_tb_top;
  import sers_pkg::*;
  localparam sers_syn_type BAD_X = {288'h0, 8'h01};
  localparam sers_syn_type BAD_M = {288'h3, 8'h00};
  logic mclk, rst, rc_valid, rc_ready, rc_end, buf_valid, buf_ready;
  logic rd_start, wr_start, cfg_wr, cfg_auto_realloc, fact_load, fw_done;
  logic fw_ok, med_ack, med_ok, med_need_fw, reread_req, fw_req, med_req;
  logic remap_valid, done, list_full, auto_realloc, fw_good, fail_fw, seen;
  logic [3:0] fail_at;
  logic [SERS_LBA_W-1:0] cmd_lba, fact_lba, phys_addr;
  logic [4:0] cmd_zone;
  logic [8:0] grown_count;
  sers_byte_type rc_byte, buf_byte;
  sers_sector_end_type rc_status;
  sers_syn_type fw_syn;
  sers_op_type med_op;
  sers_remap_type remap, got_map;
  sers_result_type result, got_res;
  int n_mismatch, checks_done, n_rr, n_fw, n_med, n_map, k;

  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  sers_top dut_u (.mclk, .rst, .rc_valid, .rc_ready, .rc_byte, .rc_end,
    .rc_status, .buf_valid, .buf_ready, .buf_byte, .rd_start, .wr_start,
    .cmd_lba, .cmd_zone, .cfg_wr, .cfg_auto_realloc, .fact_load,
    .fact_lba, .fw_done, .fw_ok, .med_ack, .med_ok, .med_need_fw,
    .phys_addr, .reread_req, .fw_req, .fw_syn, .med_req, .med_op,
    .remap_valid, .remap, .done, .result, .list_full, .auto_realloc,
    .grown_count);
  sers_media_model model_u (.mclk, .rst, .med_req, .fw_req, .done,
    .fw_good, .fail_fw, .fail_at, .med_ack, .med_ok, .med_need_fw,
    .fw_done, .fw_ok);
  always @(posedge mclk) begin
    if (reread_req) n_rr++;
    if (fw_req) n_fw++;
    if (med_req) n_med++;
    if (remap_valid) begin
      n_map++;
      got_map = remap;
    end
    if (done) begin
      seen = 1;
      got_res = result;
    end
  end

  // ==========
  // checking and bus tasks
  task automatic chk_v(input logic [63:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_v
  task automatic chk_res(input sers_result_type got, exp);
    chk_v(32'(got), 32'(exp), "result");
  endtask : chk_res
  task automatic end_sec(input logic otf, input sers_syn_type syn);
    @(negedge mclk);
    rc_end = 1;
    rc_status = {otf, syn};
    @(negedge mclk);
    rc_end = 0;
    rc_status = ~rc_status;
    repeat (3) @(negedge mclk);
  endtask : end_sec
  task automatic start(input logic wr, input logic [31:0] lba);
    {n_rr, n_fw, n_med, n_map, seen} = '0;
    @(negedge mclk);
    cmd_lba = lba;
    {wr_start, rd_start} = {wr, !wr};
    @(negedge mclk);
    {wr_start, rd_start} = 2'b00;
  endtask : start
  task automatic wait_done;
    for (k = 0; k < 400 && !seen; k++) @(negedge mclk);
    chk_v(32'(seen), 1, "done");
  endtask : wait_done
  task automatic do_read(input logic [31:0] lba, input logic otf,
                         input int n_bad, input logic fix);
    start(0, lba);
    end_sec(otf, BAD_M);
    for (int i = 0; i < n_bad; i++) end_sec(0, i[0] ? BAD_M : BAD_X);
    if (fix) end_sec(0, {288'h0, 8'hff});
    wait_done();
  endtask : do_read
  task automatic set_auto(input logic v);
    @(negedge mclk);
    cfg_auto_realloc = v;
    cfg_wr = 1;
    @(negedge mclk);
    cfg_wr = 0;
    chk_v(auto_realloc, v, "auto");
  endtask : set_auto

  // ==========
  // scenarios
  task automatic t_factory;
    @(negedge mclk);
    fact_lba = 32'ha;
    fact_load = 1;
    @(negedge mclk);
    fact_load = 0;
    cmd_lba = 32'h9;
    repeat (3) @(negedge mclk);
    chk_v(phys_addr, 32'h9, "below defect");
    cmd_lba = 32'hc;
    repeat (3) @(negedge mclk);
    chk_v(phys_addr, 32'hd, "past defect");
    $display("test factory finished");
  endtask : t_factory
  task automatic t_stream;
    int n, m;
    {n, m, buf_ready} = '0;
    while (rc_ready === 1'b1 && n < 40) begin
      rc_valid = 1;
      rc_byte = {8'(n + 8'h30), n == 15};
      @(negedge mclk);
      n++;
    end
    rc_valid = 0;
    rc_byte = ~rc_byte;
    chk_v(n, 17, "fifo room");
    // drain with the buffer stalling every other cycle
    for (k = 0; k < 60; k++) begin
      buf_ready = k[0];
      if (k[0] && buf_valid === 1'b1) begin
        chk_v(buf_byte, {8'(m + 8'h30), m == 15}, "byte");
        m++;
      end
      @(negedge mclk);
    end
    chk_v({buf_valid, 8'(m)}, 9'h11, "drained");
    buf_ready = 1;
    do_read(32'h2, 1, 0, 0);
    chk_v(n_rr, 0, "no re-read");
    chk_res(got_res, RES_OK);
    $display("test stream finished");
  endtask : t_stream
  task automatic t_retry;
    do_read(32'h7, 0, 3, 1);
    chk_v(n_rr, 4, "re-reads");
    chk_v(n_fw, 0, "no firmware");
    chk_res(got_res, RES_OK);
    $display("test retry finished");
  endtask : t_retry
  task automatic t_test;
    do_read(32'h30, 0, 8, 0);
    chk_v(n_med, 8, "test ops");
    chk_res(got_res, RES_CORRECTED);
    fail_at = 4'h3;
    fail_fw = 1;
    do_read(32'h31, 0, 8, 0);
    chk_v(n_map, 1, "remapped");
    chk_v({got_map.zone, got_map.slot}, {5'h3, 5'h1f}, "spare");
    chk_v(got_map.lba, 32'h31, "lba");
    chk_v(grown_count, 1, "grown");
    {fail_at, fail_fw} = 5'h1e;
    set_auto(0);
    do_read(32'h50, 0, 8, 0);
    chk_v(n_med, 0, "no test");
    chk_res(got_res, RES_CORRECTED);
    set_auto(1);
    $display("test media finished");
  endtask : t_test
  task automatic t_pending;
    fw_good = 0;
    do_read(32'h14, 0, 8, 0);
    chk_v({n_rr, n_fw}, {32'h8, 32'h1}, "retry end");
    chk_res(got_res, RES_FAILED);
    start(1, 32'h14);
    wait_done();
    chk_v({n_med, n_map}, {32'h9, 32'h0}, "in place");
    start(1, 32'h14);
    wait_done();
    chk_v(n_med, 0, "entry gone");
    do_read(32'h28, 0, 8, 0);
    fail_at = 4'h2;
    start(1, 32'h28);
    wait_done();
    chk_v({n_map, got_map.permanent}, 33'h3, "permanent");
    chk_res(got_res, RES_OK);
    $display("test pending finished");
  endtask : t_pending

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #300us;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    rst = 1;
    {rc_valid, rc_end, rd_start, wr_start, cfg_wr, fact_load} = '0;
    {cfg_auto_realloc, buf_ready, fw_good, fail_fw} = 4'b1110;
    {fail_at, cmd_zone, cmd_lba, fact_lba} = {4'hf, 5'h3, 64'h0};
    {rc_byte, rc_status} = '0;
    {n_mismatch, checks_done} = '0;
    repeat (5) @(negedge mclk);
    rst = 0;
    chk_v({auto_realloc, grown_count}, 10'h200, "reset");
    t_factory();
    t_stream();
    t_retry();
    t_test();
    t_pending();
    report_and_stop();
  end
endmodule : sers_tb_top
